// >>> logic/ubr_defines.svh
// Register offsets, field positions, reset values and divide counts for the baud generator
`ifndef UBR_DEFINES_SVH
`define UBR_DEFINES_SVH
`define UBR_ADDR_BAUD_CTRL 8'h9E
`define UBR_ADDR_FRAC_DIV 8'h9D
`define UBR_ADDR_SERIAL_BUF 8'h99
`define UBR_CTRL_ENABLE_BIT 7
`define UBR_CTRL_DIV_MSB 2
`define UBR_FRAC_MSB 5
`define UBR_CTRL_RESET 8'h00
`define UBR_FRAC_RESET 8'h00
`define UBR_DIV_MAX 3'h6
`define UBR_FRAC_OFFSET 15'h0040
`define UBR_ACC_STEP 15'h0004
`define UBR_SHIFT_DIV 4'hB
`define UBR_FIX_DIV_SLOW 5'h1F
`define UBR_FIX_DIV_FAST 5'h0F
`define UBR_OVF_DIV_SLOW 5'h1F
`define UBR_OVF_DIV_FAST 5'h0F
`define UBR_T1_AUTORELOAD 4'h2
`endif

// >>> logic/ubr_pkg.sv
// Types shared by the serial baud-rate generator
package ubr_pkg;
    typedef enum logic [1:0] {
        UBR_SHIFT = 2'b00,
        UBR_VAR8 = 2'b01,
        UBR_VAR9 = 2'b11,
        UBR_FIX9 = 2'b10
    } ubr_mode_e;

    typedef struct packed {
        logic rateEnable;
        logic [2:0] divider;
        logic [5:0] fracDiv;
        logic [14:0] fracAcc;
        logic [3:0] shiftCnt;
        logic [4:0] fixCnt;
        logic [1:0][4:0] ovfCnt;
        logic [7:0] t1Cnt;
        logic [15:0] t2Cnt;
        logic [2:0] rxdSync;
        logic rxdLevel;
        logic shiftRxReady;
        logic [7:0] readData;
        logic txStart;
        logic rxStart;
        logic txBitTick;
        logic rxBitTick;
        logic nineBitFrame;
        logic shiftRegisterMode;
    } ubr_state_s;
endpackage

// >>> logic/ubr_baud_gen.sv
// Serial port baud-rate generation and transfer start
// Function
// [RULE1] Two mode bits pick shift mode, 8-bit variable, 9-bit fixed, 9-bit variable.
// [RULE2] Mode 3 frames like mode 2 but takes the variable timer rate.
// [RULE3] Any write to the serial data buffer starts a transmission.
// [RULE4] Shift mode receives only while receive flag low and receive enable high.
// [RULE5] Modes 1-3 receive on a detected start bit when receive enabled.
// [RULE6] Shift mode rate is core clock over 12, nothing else matters.
// [RULE7] Mode 2 rate is core over 32, or over 16 with doubling set; the code keeps 32 while the dedicated enable is set.
// [RULE8] Variable modes use timer 1 or 2 overflows, chosen per direction.
// [RULE9] Timer 1 rate is overflow rate times two-to-doubling over 32.
// [RULE10] Software keeps timer 1 interrupt off; timer may run any mode.
// [RULE11] Timer 1 auto-reload gives two-to-doubling/32 times core over 256-minus-reload.
// [RULE12] Timer 2 source gives one bit per 16 overflows.
// [RULE13] Timer 2 reloads from its 16-bit pair; rate core/(16*(65536-reload)).
// [RULE14] Timer 2 transmit/receive selects put timer 2 in rate mode per direction.
// [RULE15] Dedicated-rate enable uses the dedicated timer, ignoring doubling and selects.
// [RULE16] With dedicated enable clear, conventional mode sources set the rate.
// [RULE17] Three-bit divider field takes values 0 through 6.
// [RULE18] Dedicated rate is 2*core over 2^(div-1) times (fraction+64).
// [RULE19] Software picks divider as floor of log2(core/(16*rate)).
// [RULE20] Software picks fraction as 2*core/(2^(div-1)*rate) minus 64, rounded.
// [RULE21] Dedicated timer covers 12 to 393216 bps within 0.8 percent.
// [RULE22] Control bits 6 to 3 are unimplemented; writes to them do nothing.
`include "ubr_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module ubr_baud_gen (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrWriteData,
    output logic [7:0] sfrReadData,
    input wire logic modeSelectHigh,
    input wire logic modeSelectLow,
    input wire logic rateDoublingBit,
    input wire logic receiveEnable,
    input wire logic receiveDoneFlag,
    input wire logic rxBusy,
    input wire logic rxdPin,
    input wire logic [3:0] timerModeHigh,
    input wire logic [7:0] timer1ReloadHigh,
    input wire logic timer1Overflow,
    input wire logic timer2TxClockSelect,
    input wire logic timer2RxClockSelect,
    input wire logic [7:0] timer2ReloadHigh,
    input wire logic [7:0] timer2ReloadLow,
    output logic txStart,
    output logic rxStart,
    output logic txBitTick,
    output logic rxBitTick,
    output logic nineBitFrame,
    output logic shiftRegisterMode
);
    import ubr_pkg::*;

    localparam ubr_state_s RESET_STATE = '{
        rateEnable: 1'b0,
        divider: 3'(`UBR_CTRL_RESET),
        fracDiv: 6'(`UBR_FRAC_RESET),
        rxdSync: 3'h7,
        rxdLevel: 1'b1,
        default: '0
    };

    function automatic logic sfrHit(input logic [7:0] addr, input logic [7:0] target);
        sfrHit = (addr == target);
    endfunction

    ubr_state_s st;
    ubr_state_s next_st;
    ubr_mode_e mode;
    logic t1AutoReload;
    logic t1Ovf;
    logic t2Ovf;
    logic t2Running;
    logic shiftTick;
    logic fixTick;
    logic fracTick;
    logic rxdFall;
    logic shiftRxCond;
    logic [1:0] dirSel;
    logic [1:0] ovfEvent;
    logic [1:0] ovfTick;
    logic [1:0] dirTick;
    logic [4:0] ovfLimit;
    logic [4:0] fixLimit;
    logic [14:0] fracLimit;
    logic [14:0] accNext;

    // [RULE1] mode decode
    assign mode = ubr_mode_e'({modeSelectHigh, modeSelectLow});

    always_comb begin
        next_st = st;

        // [RULE17] divider clamp
        // [RULE22] bits 6..3 dropped
        if (sfrWrite && sfrHit(sfrAddr, `UBR_ADDR_BAUD_CTRL)) begin
            next_st.rateEnable = sfrWriteData[`UBR_CTRL_ENABLE_BIT];
            if (sfrWriteData[`UBR_CTRL_DIV_MSB:0] > `UBR_DIV_MAX) begin
                next_st.divider = `UBR_DIV_MAX;
            end else begin
                next_st.divider = sfrWriteData[`UBR_CTRL_DIV_MSB:0];
            end
        end
        if (sfrWrite && sfrHit(sfrAddr, `UBR_ADDR_FRAC_DIV)) begin
            next_st.fracDiv = sfrWriteData[`UBR_FRAC_MSB:0];
        end

        // Unimplemented bits and unknown addresses read back as zero
        if (sfrHit(sfrAddr, `UBR_ADDR_BAUD_CTRL)) begin
            next_st.readData = {st.rateEnable, 4'h0, st.divider};
        end else if (sfrHit(sfrAddr, `UBR_ADDR_FRAC_DIV)) begin
            next_st.readData = {2'b00, st.fracDiv};
        end else begin
            next_st.readData = 8'h00;
        end

        // [RULE3] transmit on buffer write
        next_st.txStart = sfrWrite && sfrHit(sfrAddr, `UBR_ADDR_SERIAL_BUF);

        // Three-stage pin sync; level moves only when stages two and three agree
        next_st.rxdSync = {st.rxdSync[1:0], rxdPin};
        rxdFall = 1'b0;
        if (st.rxdSync[1] == st.rxdSync[2]) begin
            next_st.rxdLevel = st.rxdSync[2];
            rxdFall = st.rxdLevel && !st.rxdSync[2];
        end

        // [RULE4] shift-mode receive gate
        shiftRxCond = (mode == UBR_SHIFT) && receiveEnable && !receiveDoneFlag && !rxBusy;
        next_st.shiftRxReady = shiftRxCond;
        // [RULE5] start-bit receive
        if (mode == UBR_SHIFT) begin
            next_st.rxStart = shiftRxCond && !st.shiftRxReady;
        end else begin
            next_st.rxStart = rxdFall && receiveEnable && !rxBusy;
        end

        // [RULE6] fixed divide by 12
        shiftTick = (st.shiftCnt == `UBR_SHIFT_DIV);
        next_st.shiftCnt = shiftTick ? 4'h0 : st.shiftCnt + 4'h1;

        // [RULE7] mode 2 divide by 32 or 16
        // [RULE15] doubling ignored when dedicated timer on
        fixLimit = (rateDoublingBit && !st.rateEnable) ? `UBR_FIX_DIV_FAST : `UBR_FIX_DIV_SLOW;
        fixTick = (st.fixCnt >= fixLimit);
        next_st.fixCnt = fixTick ? 5'h00 : st.fixCnt + 5'h01;

        // [RULE11] timer 1 eight-bit auto-reload at core rate
        t1AutoReload = (timerModeHigh == `UBR_T1_AUTORELOAD);
        t1Ovf = 1'b0;
        if (t1AutoReload) begin
            if (st.t1Cnt == 8'hFF) begin
                next_st.t1Cnt = timer1ReloadHigh;
                t1Ovf = 1'b1;
            end else begin
                next_st.t1Cnt = st.t1Cnt + 8'h01;
            end
        end else begin
            // Other timer 1 modes run outside; their overflow pulse is used as is
            t1Ovf = timer1Overflow;
        end

        // [RULE13] timer 2 sixteen-bit reload
        // [RULE14] selects start rate mode
        t2Running = (timer2TxClockSelect || timer2RxClockSelect) && !st.rateEnable;
        t2Ovf = 1'b0;
        if (t2Running) begin
            if (st.t2Cnt == 16'hFFFF) begin
                next_st.t2Cnt = {timer2ReloadHigh, timer2ReloadLow};
                t2Ovf = 1'b1;
            end else begin
                next_st.t2Cnt = st.t2Cnt + 16'h0001;
            end
        end

        // [RULE8] per-direction timer choice
        // [RULE14] tx and rx selects independent
        dirSel = {timer2RxClockSelect, timer2TxClockSelect};
        for (int d = 0; d < 2; d++) begin
            ovfEvent[d] = dirSel[d] ? t2Ovf : t1Ovf;
            // [RULE9] timer 1 divide 32 or 16
            // [RULE12] timer 2 divide 16
            if (dirSel[d] || rateDoublingBit) begin
                ovfLimit = `UBR_OVF_DIV_FAST;
            end else begin
                ovfLimit = `UBR_OVF_DIV_SLOW;
            end
            ovfTick[d] = 1'b0;
            if (ovfEvent[d]) begin
                if (st.ovfCnt[d] >= ovfLimit) begin
                    next_st.ovfCnt[d] = 5'h00;
                    ovfTick[d] = 1'b1;
                end else begin
                    next_st.ovfCnt[d] = st.ovfCnt[d] + 5'h01;
                end
            end
        end

        // [RULE18] fractional accumulator, period (frac+64)*2^div/4 clocks
        // [RULE21] exact average rate over the full range
        fracLimit = (`UBR_FRAC_OFFSET + {9'h000, st.fracDiv}) << st.divider;
        accNext = st.fracAcc + `UBR_ACC_STEP;
        fracTick = 1'b0;
        if (!st.rateEnable) begin
            next_st.fracAcc = 15'h0000;
        end else if (accNext >= fracLimit) begin
            next_st.fracAcc = accNext - fracLimit;
            fracTick = 1'b1;
        end else begin
            next_st.fracAcc = accNext;
        end

        // [RULE16] conventional sources when dedicated off
        // [RULE15] dedicated timer overrides variable modes
        // [RULE2] mode 3 rate as mode 1
        for (int d = 0; d < 2; d++) begin
            case (mode)
                UBR_SHIFT: dirTick[d] = shiftTick;
                UBR_FIX9: dirTick[d] = fixTick;
                UBR_VAR8, UBR_VAR9: dirTick[d] = st.rateEnable ? fracTick : ovfTick[d];
                default: dirTick[d] = 1'b0;
            endcase
        end
        next_st.txBitTick = dirTick[0];
        next_st.rxBitTick = dirTick[1];

        // [RULE2] nine-bit framing in modes 2 and 3
        next_st.nineBitFrame = (mode == UBR_FIX9) || (mode == UBR_VAR9);
        next_st.shiftRegisterMode = (mode == UBR_SHIFT);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= RESET_STATE;
        end else begin
            st <= next_st;
        end
    end

    assign sfrReadData = st.readData;
    assign txStart = st.txStart;
    assign rxStart = st.rxStart;
    assign txBitTick = st.txBitTick;
    assign rxBitTick = st.rxBitTick;
    assign nineBitFrame = st.nineBitFrame;
    assign shiftRegisterMode = st.shiftRegisterMode;
endmodule // ubr_baud_gen

`default_nettype wire

// >>> sim/ubr_baud_gen_chk.sv
// Port checker for the baud generator
`timescale 1ns/1ps
`default_nettype none
module ubr_baud_gen_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrWriteData,
    input wire logic [7:0] sfrReadData,
    input wire logic modeSelectHigh,
    input wire logic modeSelectLow,
    input wire logic rateDoublingBit,
    input wire logic receiveEnable,
    input wire logic receiveDoneFlag,
    input wire logic timer2TxClockSelect,
    input wire logic [7:0] timer2ReloadHigh,
    input wire logic [7:0] timer2ReloadLow,
    input wire logic txStart,
    input wire logic rxStart,
    input wire logic txBitTick,
    input wire logic nineBitFrame,
    input wire logic shiftRegisterMode
);
    int gap;
    logic seen;
    logic baudOn;
    // Gap is only trusted after a first tick, since the dividers start mid-phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap <= 0;
            seen <= 1'b0;
            baudOn <= 1'b0;
        end else begin
            gap <= txBitTick ? 0 : gap + 1;
            seen <= seen | txBitTick;
            if (sfrWrite && sfrAddr == 8'h9E) begin
                baudOn <= sfrWriteData[7];
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence sBufWrite;
        sfrWrite && sfrAddr == 8'h99;
    endsequence
    sequence sTickSeen;
        txBitTick && seen;
    endsequence
    a_tx_on_write: assert property (sBufWrite |=> txStart)
        else $error("no transmit start after buffer write");
    a_tx_has_cause: assert property (txStart |-> $past(sfrWrite && sfrAddr == 8'h99))
        else $error("transmit start without buffer write");
    a_shift_flag: assert property (!modeSelectHigh && !modeSelectLow |=> shiftRegisterMode)
        else $error("shift mode flag missing");
    a_nine_flag: assert property (modeSelectHigh |=> nineBitFrame)
        else $error("nine bit frame flag missing");
    a_ctrl_gap_zero: assert property ($past(sfrAddr) == 8'h9E |-> sfrReadData[6:3] == 4'h0)
        else $error("unused control bits read nonzero");
    a_rx_gate: assert property (rxStart |-> $past(receiveEnable)
        && !(shiftRegisterMode && $past(receiveDoneFlag)))
        else $error("receive started while gated");
    a_shift_rate: assert property (sTickSeen and shiftRegisterMode |-> gap == 11)
        else $error("shift mode tick spacing wrong");
    a_fixed_rate: assert property (sTickSeen and modeSelectHigh && !modeSelectLow
        |-> gap == ((rateDoublingBit && !baudOn) ? 15 : 31))
        else $error("fixed mode tick spacing wrong");
    a_t2_rate: assert property (sTickSeen and modeSelectLow && !baudOn && timer2TxClockSelect
        |-> gap == 16 * (65536 - {timer2ReloadHigh, timer2ReloadLow}) - 1)
        else $error("timer 2 tick spacing wrong");
endmodule // ubr_baud_gen_chk
bind ubr_baud_gen ubr_baud_gen_chk i_chk (.clk, .rst_n, .sfrAddr, .sfrWrite, .sfrWriteData, .sfrReadData,
    .modeSelectHigh, .modeSelectLow, .rateDoublingBit, .receiveEnable, .receiveDoneFlag, .timer2TxClockSelect,
    .timer2ReloadHigh, .timer2ReloadLow, .txStart, .rxStart, .txBitTick, .nineBitFrame, .shiftRegisterMode);
`default_nettype wire

// >>> sim/ubr_line_model.sv
// Remote serial transmitter driving the receive line
`timescale 1ns/1ps
`default_nettype none
module ubr_line_model (
    input wire logic clk,
    output logic rxd
);
    // Line idles high between frames, as a pulled-up wire would
    initial rxd = 1'b1;
    task automatic send(input logic [7:0] data, input int bitClks);
        logic [9:0] frame;
        frame = {1'b1, data, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk);
            rxd = frame[i];
            repeat (bitClks - 1) @(negedge clk);
        end
    endtask
endmodule // ubr_line_model
`default_nettype wire

// >>> sim/ubr_baud_gen_tb_top.sv
// Self-checking bench for the baud generator
`timescale 1ns/1ps
`default_nettype none
module ubr_baud_gen_tb_top;
    logic clk, rst_n, sfrWrite, modeSelectHigh, modeSelectLow, rateDoublingBit, receiveEnable, receiveDoneFlag;
    logic rxBusy, timer1Overflow, timer2TxClockSelect, timer2RxClockSelect;
    logic txStart, rxStart, txBitTick, rxBitTick, nineBitFrame, shiftRegisterMode;
    logic [7:0] sfrAddr, sfrWriteData, sfrReadData, timer1ReloadHigh, timer2ReloadHigh, timer2ReloadLow;
    logic [3:0] timerModeHigh;
    wire rxdPin;
    int err_count, total_checks, n;
    int ovfCnt = 0;
    ubr_line_model i_line (.clk, .rxd(rxdPin));
    ubr_baud_gen i_dut (.clk, .rst_n, .sfrAddr, .sfrWrite, .sfrWriteData, .sfrReadData, .modeSelectHigh,
        .modeSelectLow, .rateDoublingBit, .receiveEnable, .receiveDoneFlag, .rxBusy, .rxdPin, .timerModeHigh,
        .timer1ReloadHigh, .timer1Overflow, .timer2TxClockSelect, .timer2RxClockSelect, .timer2ReloadHigh,
        .timer2ReloadLow, .txStart, .rxStart, .txBitTick, .rxBitTick, .nineBitFrame, .shiftRegisterMode);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // External timer 1 overflow every third clock, no timer interrupt
    always @(negedge clk) begin
        ovfCnt <= (ovfCnt == 2) ? 0 : ovfCnt + 1;
        timer1Overflow <= (ovfCnt == 2);
    end
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfrAddr = a;
        sfrWrite = 1'b1;
        sfrWriteData = d;
        @(negedge clk);
        sfrWrite = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        sfrAddr = a;
        repeat (2) @(negedge clk);
        check(sfrReadData, exp, "readback");
    endtask
    task automatic catchp(input int which, input int lim, input logic must, output int cnt);
        cnt = -1;
        for (int i = 0; i < lim && cnt < 0; i++) begin
            @(negedge clk);
            if ((which == 0) ? txBitTick === 1'b1 : (which == 1) ? rxBitTick === 1'b1 : rxStart === 1'b1) cnt = i;
        end
        if (must && cnt < 0) begin
            err_count++;
            $display("CHECK FAILED pulse wait expected pulse seen none");
            give_verdict();
        end
    endtask
    task automatic rst(input logic [1:0] m, input logic dbl, input logic [3:0] tmh, input logic tx2, input logic rx2);
        @(negedge clk);
        rst_n = 1'b0;
        {modeSelectHigh, modeSelectLow} = m;
        rateDoublingBit = dbl;
        timerModeHigh = tmh;
        timer2TxClockSelect = tx2;
        timer2RxClockSelect = rx2;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
    endtask
    // Third tick is measured: the first gap may span a divider change
    task automatic rate(input logic [1:0] m, input logic dbl, input logic [3:0] tmh, input logic tx2, input logic rx2,
        input logic [7:0] ctrl, input logic [7:0] frac, input int txP, input int rxP);
        rst(m, dbl, tmh, tx2, rx2);
        wr(8'h9D, frac);
        wr(8'h9E, ctrl);
        for (int w = 0; w < 2; w++) begin
            // Timer 2 starts from zero after reset, so its first overflow takes a full wrap
            repeat (3) catchp(w, 70000, 1'b1, n);
            check(n + 1, w ? rxP : txP, "tick period");
        end
    endtask
    initial begin
        {rst_n, sfrWrite, sfrAddr, sfrWriteData, receiveEnable, receiveDoneFlag, rxBusy} = '0;
        {err_count, total_checks} = '0;
        timer1ReloadHigh = 8'hFE;
        {timer2ReloadHigh, timer2ReloadLow} = 16'hFFFE;
        rst(2'b00, 1'b0, 4'h0, 1'b0, 1'b0);
        rd(8'h9E, 8'h00);
        rd(8'h9D, 8'h00);
        rd(8'h55, 8'h00);
        wr(8'h9E, 8'h07);
        rd(8'h9E, 8'h06);
        wr(8'h9E, 8'hFA);
        rd(8'h9E, 8'h82);
        wr(8'h9D, 8'hFF);
        rd(8'h9D, 8'h3F);
        @(negedge clk);
        sfrAddr = 8'h99;
        sfrWrite = 1'b1;
        repeat (2) begin
            @(negedge clk);
            check(txStart, 1'b1, "txStart");
        end
        sfrWrite = 1'b0;
        @(negedge clk);
        check(txStart, 1'b0, "txStart");
        rate(2'b00, 1'b1, 4'h0, 1'b1, 1'b1, 8'h00, 8'h00, 12, 12);
        rate(2'b10, 1'b0, 4'h2, 1'b0, 1'b0, 8'h00, 8'h00, 32, 32);
        rate(2'b10, 1'b1, 4'h2, 1'b0, 1'b0, 8'h00, 8'h00, 16, 16);
        rate(2'b01, 1'b0, 4'h2, 1'b0, 1'b0, 8'h00, 8'h00, 64, 64);
        rate(2'b01, 1'b1, 4'h2, 1'b0, 1'b0, 8'h00, 8'h00, 32, 32);
        rate(2'b11, 1'b0, 4'h0, 1'b0, 1'b0, 8'h00, 8'h00, 96, 96);
        rate(2'b01, 1'b0, 4'h2, 1'b1, 1'b0, 8'h00, 8'h00, 32, 64);
        // Divider 1 and fraction 12 as software picks for a 38-clock bit
        rate(2'b11, 1'b1, 4'h2, 1'b1, 1'b1, 8'hF9, 8'h0C, 38, 38);
        rst(2'b01, 1'b0, 4'h2, 1'b0, 1'b0);
        receiveEnable = 1'b1;
        fork
            i_line.send(8'h5A, 16);
            catchp(2, 12, 1'b1, n);
        join
        receiveEnable = 1'b0;
        fork
            i_line.send(8'hA5, 16);
            catchp(2, 12, 1'b0, n);
        join
        check(n < 0, 1'b1, "rx while disabled");
        rst(2'b00, 1'b0, 4'h0, 1'b0, 1'b0);
        receiveDoneFlag = 1'b1;
        receiveEnable = 1'b1;
        catchp(2, 6, 1'b0, n);
        check(n < 0, 1'b1, "rx with flag set");
        receiveDoneFlag = 1'b0;
        catchp(2, 6, 1'b1, n);
        give_verdict();
    end
endmodule // ubr_baud_gen_tb_top
`default_nettype wire
